// >>> common/cmd_parser_pkg.sv
package cmd_parser_pkg;

	// ==========================================================
	// Character codes used by the parser and the reply framer.
	// ==========================================================
	localparam logic [7:0] CH_START = 8'h23;   // Start-of-message character.
	localparam logic [7:0] CH_CR = 8'h0D;      // Carriage return, end of command.
	localparam logic [7:0] CH_LF = 8'h0A;      // Line feed, sent after CR.
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;

	// ==========================================================
	// Command field values.
	// ==========================================================
	localparam logic [3:0] GRP_MODE = 4'h0;        // Mode control group.
	localparam logic [3:0] SUB_CMD_MODE = 4'h1;    // #01 enters command mode.
	localparam logic [3:0] SUB_DATA_MODE = 4'h0;   // #00 returns to data mode.
	localparam logic [3:0] GRP_COMM = 4'h1;        // Communications port control.
	localparam logic [3:0] SUB_MAIN_PORT = 4'h0;   // Main serial port subgroup.
	localparam logic [3:0] CMD_BAUD = 4'h0;        // Baud-rate command digit.
	localparam logic [3:0] BAUD_RESET = 4'h5;      // 9600 baud, factory default.

	// ==========================================================
	// Command buffer sizing and reply lengths.
	// ==========================================================
	localparam int MAX_DIGITS = 8;         // Digits kept after the start character.
	localparam int MIN_DIGITS = 2;         // Shortest valid command.
	localparam int LONG_SETTING = 4;       // Digits of a long setting; only the first is checked as hex.
	localparam logic [3:0] REPLY_DONE_LEN = 4'h7;   // "#Done" CR LF, seven characters.
	localparam logic [3:0] REPLY_ERROR_LEN = 4'h8;  // "#Error" CR LF, eight characters.

	// Reply kinds.
	typedef enum logic [1:0] {
		REPLY_NONE = 2'b00,
		REPLY_DONE = 2'b01,
		REPLY_ERROR = 2'b10
	} reply_t;

endpackage

// >>> rtl/reply_framer.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Reply framer: sends #Done or #Error followed by CR and LF.
// ==========================================================
module reply_framer
	import cmd_parser_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire reply_t kind,
	output logic busy,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady
);

	logic [3:0] idx_q, idx_d;       // Index of the next character to send.
	logic busy_q, busy_d;           // High while a reply is in flight.
	reply_t kind_q, kind_d;         // Kind of the reply being sent.
	logic [7:0] data_q, data_d;     // Registered outgoing character.
	logic valid_q, valid_d;         // Registered character strobe.
	logic [3:0] lenNow;             // Length of the current reply.
	logic [7:0] charNow;            // Character at the current index.

	// Looks up the character at the current index for this kind.
	always_comb begin
		lenNow = (kind_q == REPLY_DONE) ? REPLY_DONE_LEN : REPLY_ERROR_LEN;
		charNow = CH_LF;
		if (idx_q == 4'h0) begin
			charNow = CH_START;
		end else if (idx_q == lenNow - 4'h2) begin
			charNow = CH_CR;
		end else if (idx_q == lenNow - 4'h1) begin
			charNow = CH_LF;
		end else if (kind_q == REPLY_DONE) begin
			case (idx_q)
				4'h1: charNow = 8'h44;
				4'h2: charNow = 8'h6F;
				4'h3: charNow = 8'h6E;
				4'h4: charNow = 8'h65;
				default: charNow = CH_LF;
			endcase
		end else begin
			case (idx_q)
				4'h1: charNow = 8'h45;
				4'h2: charNow = 8'h72;
				4'h3: charNow = 8'h72;
				4'h4: charNow = 8'h6F;
				4'h5: charNow = 8'h72;
				default: charNow = CH_LF;
			endcase
		end
	end

	// Steps through the reply one character per accepted handshake.
	always_comb begin
		idx_d = idx_q;
		busy_d = busy_q;
		kind_d = kind_q;
		data_d = data_q;
		valid_d = valid_q;
		if (valid_q && txReady) begin
			// The character was taken; drop the strobe, for one cycle unless it was the closing LF.
			valid_d = 1'b0;
			if (idx_q == lenNow - 4'h1) begin
				busy_d = 1'b0;
				idx_d = 4'h0;
			end else begin
				idx_d = idx_q + 4'h1;
			end
		end else if (busy_q && !valid_q) begin
			// Presents the next character.
			data_d = charNow;
			valid_d = 1'b1;
		end else if (!busy_q && start) begin
			// Accepts a new reply request.
			busy_d = 1'b1;
			kind_d = kind;
			idx_d = 4'h0;
		end
	end

	// Registers the framer state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 4'h0;
			busy_q <= 1'b0;
			kind_q <= REPLY_NONE;
			data_q <= 8'h00;
			valid_q <= 1'b0;
		end else begin
			idx_q <= idx_d;
			busy_q <= busy_d;
			kind_q <= kind_d;
			data_q <= data_d;
			valid_q <= valid_d;
		end
	end

	assign busy = busy_q;
	assign txData = data_q;
	assign txValid = valid_q;

endmodule // reply_framer

`default_nettype wire

// >>> rtl/serial_command_parser.sv
`timescale 1ns/100ps
`default_nettype none

module serial_command_parser
	import cmd_parser_pkg::*;
#(
	parameter int DIGITS = MAX_DIGITS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	output logic cmdMode,
	output logic [3:0] baudSel,
	output logic baudWrite,
	output logic [15:0] longSetting,
	output logic longSettingValid,
	output logic [3:0] cmdGroup,
	output logic [3:0] cmdSub,
	output logic [3:0] cmdDigit,
	output logic [3:0] cmdSetting,
	output logic [3:0] cmdLength,
	output logic cmdValid
);

	// Overview of the flow through this block.
	// A start character opens a message and a carriage return closes it.
	// Characters outside such a frame are dropped without an answer.
	// Up to DIGITS characters are kept; the first four must be hex digits.
	// The closed message is decoded once the reply framer is free.
	// Every closed message gets exactly one reply, Done or Error.
	// The framer adds the start character and the closing CR and LF.
	// Strobes, levels and cmdLength come from registers, one cycle after decode; field outputs read the digit buffer.
	// Strobes stand for a single cycle; levels hold until the next command.
	// Command mode and the baud code survive until changed or reset.
	// Characters that arrive while a reply is pending are ignored.
	// A host must therefore wait for the closing LF before sending again.

	// ==========================================================
	// Receive collection state.
	// ==========================================================
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COLLECT = 2'b01,
		ST_EXEC = 2'b10
	} parse_state_t;

	parse_state_t state_q, state_d;             // Collection state.
	logic [3:0] digits_q [DIGITS];              // Hex values of collected digits.
	logic [3:0] digitsNext [DIGITS];            // Next values of the digit buffer.
	logic [3:0] count_q, count_d;               // Number of characters collected.
	logic bad_q, bad_d;                         // A non-hex character was seen in the first four.
	logic overflow_q, overflow_d;               // More characters than the buffer holds.
	logic cmdMode_q, cmdMode_d;                 // Command mode flag.
	logic [3:0] baud_q, baud_d;                 // Main port baud selection.
	logic baudWr_q, baudWr_d;                   // One-cycle baud update strobe.
	logic [15:0] long_q, long_d;                // Last four-digit setting.
	logic longValid_q, longValid_d;             // One-cycle long setting strobe.
	logic cmdValid_q, cmdValid_d;               // One-cycle decoded command strobe.
	logic [3:0] cmdLen_q, cmdLen_d;             // Length of the last command.
	logic replyStart;                           // Requests a reply from the framer.
	reply_t replyKind;                          // Kind of reply requested.
	logic framerBusy;                           // Framer still sending.
	logic isHex;                                // Incoming character is a hex digit.
	logic [3:0] hexVal;                         // Value of the incoming hex digit.
	// Decode results of the collected message.
	logic wellFormed; // Length and hex fields are legal.
	logic isModeOn; // Message is the command-mode request.
	logic isModeOff; // Message is the data-mode request.
	logic isBaud; // Message is a main-port baud command.
	logic isLong; // Message carries a four-digit setting.

	// Converts the incoming character to a hex value when it is legal.
	always_comb begin
		isHex = 1'b0;
		hexVal = 4'h0;
		if (rxData >= CH_0 && rxData <= CH_9) begin
			// Decimal digits map straight to 0 to 9.
			isHex = 1'b1;
			hexVal = 4'(rxData - CH_0);
		end else if (rxData >= CH_A && rxData <= CH_F) begin
			// Upper-case A to F map to 10 to 15; lower case is not a digit.
			isHex = 1'b1;
			hexVal = 4'(rxData - CH_A + 8'h0A);
		end
	end

	// ==========================================================
	// Command decode of the collected digits.
	// ==========================================================

	// Classifies the collected message; the dispatch below only acts on it.
	always_comb begin
		wellFormed = 1'b1;
		isModeOn = 1'b0;
		isModeOff = 1'b0;
		isBaud = 1'b0;
		isLong = 1'b0;
		if (count_q < 4'(MIN_DIGITS) || bad_q || overflow_q) begin
			// Too short, a bad field digit, or more than the buffer holds.
			wellFormed = 1'b0;
		end
		if (digits_q[0] == GRP_MODE && count_q == 4'h2) begin
			// The two-digit mode commands.
			isModeOn = (digits_q[1] == SUB_CMD_MODE);
			isModeOff = (digits_q[1] == SUB_DATA_MODE);
		end
		if (digits_q[0] == GRP_COMM && digits_q[1] == SUB_MAIN_PORT) begin
			// The baud command takes exactly one setting digit.
			isBaud = (digits_q[2] == CMD_BAUD && count_q == 4'h4);
		end
		// Three field digits followed by a four-digit setting.
		isLong = (count_q == 4'(3 + LONG_SETTING));
	end

	// ==========================================================
	// Collection, decode and dispatch.
	// ==========================================================

	// Computes the next parser state and the actions of a finished command.
	always_comb begin
		// Every register holds unless a branch moves it; strobes fall back to zero.
		state_d = state_q;
		digitsNext = digits_q;
		count_d = count_q;
		bad_d = bad_q;
		overflow_d = overflow_q;
		cmdMode_d = cmdMode_q;
		baud_d = baud_q;
		baudWr_d = 1'b0;
		long_d = long_q;
		longValid_d = 1'b0;
		cmdValid_d = 1'b0;
		cmdLen_d = cmdLen_q;
		replyStart = 1'b0;
		replyKind = REPLY_ERROR;
		case (state_q)
			ST_IDLE: begin
				// Anything but a start character is dropped here.
				if (rxValid && rxData == CH_START) begin
					// A start character opens a fresh, empty message.
					state_d = ST_COLLECT;
					count_d = 4'h0;
					bad_d = 1'b0;
					overflow_d = 1'b0;
				end
			end
			ST_COLLECT: begin
				if (rxValid) begin
					if (rxData == CH_START) begin
						// A new start character restarts the message.
						count_d = 4'h0;
						bad_d = 1'b0;
						overflow_d = 1'b0;
					end else if (rxData == CH_CR) begin
						// Carriage return closes the message.
						state_d = ST_EXEC;
					end else if (count_q == 4'(DIGITS)) begin
						// The buffer is full; the message can only fail now.
						overflow_d = 1'b1;
					end else begin
						// String settings keep their low nibble; hex check covers fields.
						if (!isHex && count_q < 4'h4) begin
							bad_d = 1'b1;
						end
						digitsNext[count_q[2:0]] = isHex ? hexVal : rxData[3:0];
						count_d = count_q + 4'h1;
					end
				end
			end
			ST_EXEC: begin
				// Waits for the framer, then answers once; characters here are dropped.
				if (!framerBusy) begin
					state_d = ST_IDLE;
					replyStart = 1'b1;
					cmdLen_d = count_q;
					if (!wellFormed) begin
						// Malformed messages raise no strobe, though cmdLength still takes their length.
						replyKind = REPLY_ERROR;
					end else begin
						cmdValid_d = 1'b1;
						if (isModeOn) begin
							// Leaves data mode for command mode.
							cmdMode_d = 1'b1;
							replyKind = REPLY_DONE;
						end else if (isModeOff) begin
							// Returns to data mode.
							cmdMode_d = 1'b0;
							replyKind = REPLY_DONE;
						end else if (cmdMode_q && isBaud) begin
							// The baud code changes only in command mode.
							baud_d = digits_q[3];
							baudWr_d = 1'b1;
							replyKind = REPLY_DONE;
						end else if (isLong) begin
							// Three field digits followed by a four-digit setting.
							long_d = {digits_q[3], digits_q[4], digits_q[5], digits_q[6]};
							longValid_d = 1'b1;
							replyKind = REPLY_DONE;
						end else begin
							// Unknown or mode-forbidden command.
							replyKind = REPLY_ERROR;
						end
					end
				end
			end
			default: begin
				// An unused state code falls back to idle.
				state_d = ST_IDLE;
			end
		endcase
	end

	// Registers the parser state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			// Empties the digit buffer.
			for (int i = 0; i < DIGITS; i++) begin
				digits_q[i] <= 4'h0;
			end
			count_q <= 4'h0;
			bad_q <= 1'b0;
			overflow_q <= 1'b0;
			cmdMode_q <= 1'b0;
			// The baud code comes up at the factory default.
			baud_q <= BAUD_RESET;
			baudWr_q <= 1'b0;
			long_q <= 16'h0000;
			longValid_q <= 1'b0;
			cmdValid_q <= 1'b0;
			cmdLen_q <= 4'h0;
		end else begin
			state_q <= state_d;
			digits_q <= digitsNext;
			count_q <= count_d;
			bad_q <= bad_d;
			overflow_q <= overflow_d;
			cmdMode_q <= cmdMode_d;
			baud_q <= baud_d;
			baudWr_q <= baudWr_d;
			long_q <= long_d;
			longValid_q <= longValid_d;
			cmdValid_q <= cmdValid_d;
			cmdLen_q <= cmdLen_d;
		end
	end

	// ==========================================================
	// Reply framing.
	// ==========================================================

	// Sends the answer to each finished command.
	// The parser waits on busy, so a second reply never cuts into the first.
	reply_framer u_framer (
		.clk(clk),
		.rst_n(rst_n),
		.start(replyStart),
		.kind(replyKind),
		.busy(framerBusy),
		.txData(txData),
		.txValid(txValid),
		.txReady(txReady)
	);

	// ==========================================================
	// Outputs.
	// ==========================================================

	// Drives the decoded command outputs from registers.
	assign cmdMode = cmdMode_q;
	assign baudSel = baud_q;
	assign baudWrite = baudWr_q;
	assign longSetting = long_q;
	assign longSettingValid = longValid_q;
	assign cmdGroup = digits_q[0];
	assign cmdSub = digits_q[1];
	assign cmdDigit = digits_q[2];
	assign cmdSetting = digits_q[3];
	assign cmdLength = cmdLen_q;
	assign cmdValid = cmdValid_q;

endmodule // serial_command_parser

`default_nettype wire

// >>> bench/cmd_parser_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker for the command parser.
module cmd_parser_props
	import cmd_parser_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic cmdMode,
	input wire logic [3:0] baudSel,
	input wire logic baudWrite,
	input wire logic longSettingValid,
	input wire logic [3:0] cmdGroup,
	input wire logic [3:0] cmdSub,
	input wire logic [3:0] cmdDigit,
	input wire logic [3:0] cmdSetting,
	input wire logic [3:0] cmdLength,
	input wire logic cmdValid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic endQ_q; // Last accepted byte closed a reply.
	logic endQ_d; // Next value of endQ_q.
	// The flag follows every accepted reply byte.
	always_comb begin
		endQ_d = endQ_q;
		if (txValid && txReady) begin
			endQ_d = (txData == CH_LF);
		end
	end
	// Registers the flag; a reply may start right after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			endQ_q <= 1'b1;
		end else begin
			endQ_q <= endQ_d;
		end
	end
	sequence crTaken;
		txValid && txReady && txData == CH_CR;
	endsequence
	sequence lfOffered;
		txValid && txData == CH_LF;
	endsequence
	hold_tx_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply byte lost");
	reply_start_a: assert property (txValid && endQ_q |-> txData == CH_START)
		else $error("reply without start");
	cr_lf_a: assert property (crTaken |-> ##[1:4] lfOffered)
		else $error("no LF after CR");
	exec_reply_a: assert property (cmdValid |=> txValid && txData == CH_START)
		else $error("no reply");
	min_len_a: assert property (cmdValid |-> cmdLength >= 4'h2 && cmdLength <= 4'h8)
		else $error("bad length");
	baud_cmd_a: assert property (baudWrite |-> cmdValid && cmdMode && cmdGroup == GRP_COMM
		&& cmdSub == SUB_MAIN_PORT && cmdDigit == CMD_BAUD && cmdLength == 4'h4)
		else $error("stray baud write");
	baud_val_a: assert property (baudWrite |-> baudSel == cmdSetting)
		else $error("baud value");
	baud_hold_a: assert property (!$stable(baudSel) |-> baudWrite)
		else $error("baud changed");
	mode_enter_a: assert property ($rose(cmdMode) |-> cmdValid && cmdGroup == GRP_MODE
		&& cmdSub == SUB_CMD_MODE && cmdLength == 4'h2)
		else $error("stray mode entry");
	long_set_a: assert property (longSettingValid |-> cmdValid && cmdLength == 4'h7)
		else $error("stray long setting");
endmodule // cmd_parser_props
`default_nettype wire

// >>> bench/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Host model: sends command lines, collects reply bytes.
module host_model
	import cmd_parser_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic slow,
	input wire logic rndBit
);
	logic [7:0] got[$]; // Reply bytes since the last clear.
	logic readyQ = 1'b0; // Ready toward the framer, one writer only.
	logic [7:0] byteQ = 8'h00; // Character on the receive line.
	logic strobeQ = 1'b0; // One-cycle receive strobe.
	assign txReady = readyQ;
	assign rxData = byteQ;
	assign rxValid = strobeQ;
	// Takes reply bytes; stalls at random while slow is set.
	always @(posedge clk) begin
		if (txValid && txReady) begin
			got.push_back(txData);
		end
		readyQ <= !slow || rndBit;
	end
	// Whole characters, one strobe each, closed by one CR.
	task automatic sendLine(input string s);
		for (int i = 0; i <= s.len(); i++) begin
			@(posedge clk);
			strobeQ <= 1'b1;
			byteQ <= (i == s.len()) ? CH_CR : s[i];
			@(posedge clk);
			strobeQ <= 1'b0;
			byteQ <= ~byteQ; // Idle line shows no stale character.
		end
	endtask
endmodule // host_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Testbench top.
module tb;
	import cmd_parser_pkg::*;
	logic clk, rst_n, txValid, txReady, rxValid, cmdMode, baudWrite, lsValid, cmdValid;
	logic [7:0] txData, rxData;
	logic [3:0] baudSel, grp, sub, dig, sett, len;
	logic [15:0] longSetting;
	logic slow = 1'b0; // Host stalls replies when set.
	logic rndBit = 1'b0;
	logic [31:0] seed = 32'h0000_0023;
	int mismatches = 0;
	int compares = 0;
	int modeM = 0; // Model command mode.
	int baudM = 5; // Model baud code.
	int pulseCv = 0; // Decoded-command strobes seen.
	int pulseBw = 0; // Baud-write strobes seen.
	int pulseLs = 0; // Long-setting strobes seen.
	serial_command_parser i_serial_command_parser (.clk(clk), .rst_n(rst_n),
		.rxData(rxData), .rxValid(rxValid), .txData(txData), .txValid(txValid),
		.txReady(txReady), .cmdMode(cmdMode), .baudSel(baudSel), .baudWrite(baudWrite),
		.longSetting(longSetting), .longSettingValid(lsValid), .cmdGroup(grp),
		.cmdSub(sub), .cmdDigit(dig), .cmdSetting(sett), .cmdLength(len), .cmdValid(cmdValid));
	host_model i_host (.clk(clk), .txData(txData), .txValid(txValid), .txReady(txReady),
		.rxData(rxData), .rxValid(rxValid), .slow(slow), .rndBit(rndBit));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Random stream for stalls and settings.
	always @(posedge clk) begin
		seed <= xs(seed);
		rndBit <= seed[0];
	end
	// Counts one-cycle strobes; each stands at exactly one rising edge.
	always @(posedge clk) begin
		if (cmdValid === 1'b1) pulseCv <= pulseCv + 1;
		if (baudWrite === 1'b1) pulseBw <= pulseBw + 1;
		if (lsValid === 1'b1) pulseLs <= pulseLs + 1;
	end
	function automatic string baudCmd(input int v);
		string s;
		s = "1000";
		s[3] = (v < 10) ? 8'h30 + v : 8'h37 + v;
		return s;
	endfunction
	task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmpReply(input string exp);
		bit ok;
		compares++;
		ok = i_host.got.size() == exp.len();
		for (int i = 0; ok && i < exp.len(); i++) ok = i_host.got[i] === exp[i];
		if (!ok) begin
			mismatches++;
			$display("mismatch %0t: reply, want %s", $time, exp);
		end
	endtask
	// Predicts, sends one line, then checks reply and state.
	task automatic run(input string pre, input string b);
		string r;
		bit ok;
		int n, expBw, expLs, cv0, bw0, ls0;
		n = b.len();
		ok = n >= MIN_DIGITS && n <= MAX_DIGITS;
		for (int i = 0; i < n && i < LONG_SETTING; i++)
			ok &= (b[i] >= "0" && b[i] <= "9") || (b[i] >= "A" && b[i] <= "F");
		r = "Error";
		expBw = 0;
		expLs = 0;
		if (ok && b == "01") begin
			modeM = 1;
			r = "Done";
		end else if (ok && b == "00") begin
			modeM = 0;
			r = "Done";
		end else if (ok && n == 4 && b.substr(0, 2) == "100" && modeM == 1) begin
			baudM = b.substr(3, 3).atohex();
			expBw = 1;
			r = "Done";
		end else if (ok && n == 7) begin
			expLs = 1;
			r = "Done";
		end
		cv0 = pulseCv;
		bw0 = pulseBw;
		ls0 = pulseLs;
		i_host.got.delete();
		i_host.sendLine({pre, "#", b});
		for (int k = 0; k < 400 && !(i_host.got.size() > 0 && i_host.got[$] == CH_LF); k++)
			@(posedge clk);
		cmpReply({"#", r, "\r\n"});
		cmpVal(baudSel, baudM);
		cmpVal(cmdMode, modeM);
		cmpVal(len, (n > MAX_DIGITS) ? MAX_DIGITS : n);
		cmpVal(pulseCv - cv0, ok);
		cmpVal(pulseBw - bw0, expBw);
		cmpVal(pulseLs - ls0, expLs);
	endtask
	task automatic summarize();
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog against a hung reply.
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		cmpVal(baudSel, BAUD_RESET);
		run("zz", "00");
		run("", "1005");
		run("#9", "01");
		run("", "1");
		run("", "100a");
		run("", "1G05");
		run("", "123456789");
		run("", "1234XYZ");
		cmpVal(longSetting, 16'h489A);
		slow <= 1'b1;
		for (int v = 0; v < 16; v++) begin
			run("", baudCmd(v));
			cmpVal({grp, sub, dig, sett}, {12'h100, v[3:0]});
		end
		repeat (4) run("", baudCmd(seed[3:0]));
		run("", "1005");
		run("", "00");
		summarize();
	end
endmodule // tb
bind serial_command_parser cmd_parser_props i_props (.clk(clk), .rst_n(rst_n),
	.txData(txData), .txValid(txValid), .txReady(txReady), .cmdMode(cmdMode),
	.baudSel(baudSel), .baudWrite(baudWrite), .longSettingValid(longSettingValid),
	.cmdGroup(cmdGroup), .cmdSub(cmdSub), .cmdDigit(cmdDigit), .cmdSetting(cmdSetting),
	.cmdLength(cmdLength), .cmdValid(cmdValid));
`default_nettype wire
